// >>> src/iod_pkg.sv
/*
 * Shared constants and types of the integer opcode decoder: opcode lines,
 * opmode and size codes, addressing modes and the decoded control bundle.
 * Assumes one clock domain and operation words delivered one per cycle.
 */
package iod_pkg;

	// ==========================================================
	// Opcode lines, bits 15..12, and the subroutine condition, bits 11..8
	// ==========================================================
	localparam logic [3:0] IOD_LINE_BRANCH = 4'h6;
	localparam logic [3:0] IOD_LINE_QUICK  = 4'h7;
	localparam logic [3:0] IOD_LINE_OR     = 4'h8;
	localparam logic [3:0] IOD_LINE_SUB    = 4'h9;
	localparam logic [3:0] IOD_LINE_CMP    = 4'hb;
	localparam logic [3:0] IOD_LINE_AND    = 4'hc;
	localparam logic [3:0] IOD_COND_SUBR   = 4'h1;

	// ==========================================================
	// Field values
	// ==========================================================
	localparam logic [7:0] IOD_DISP_WORD    = 8'h00;
	localparam logic [7:0] IOD_DISP_LONG    = 8'hff;
	localparam logic [2:0] IOD_OPM_WORD_A   = 3'h3;
	localparam logic [2:0] IOD_OPM_LONG_A   = 3'h7;
	localparam logic [1:0] IOD_OPM_ADDR_LOW = 2'h3;
	localparam logic [1:0] IOD_SZ_CODE_B    = 2'h0;
	localparam logic [1:0] IOD_SZ_CODE_W    = 2'h1;
	localparam logic [1:0] IOD_SZ_CODE_L    = 2'h2;
	localparam logic [1:0] IOD_PAIR_FORM    = 2'h0;
	localparam logic [2:0] IOD_MODE_DREG    = 3'h0;
	localparam logic [2:0] IOD_MODE_AREG    = 3'h1;
	localparam logic [2:0] IOD_MODE_PREDEC  = 3'h4;
	localparam logic [2:0] IOD_MODE_DISP    = 3'h5;
	localparam logic [2:0] IOD_MODE_INDEX   = 3'h6;
	localparam logic [2:0] IOD_MODE_EXT     = 3'h7;
	localparam logic [2:0] IOD_XREG_ABS_W   = 3'h0;
	localparam logic [2:0] IOD_XREG_ABS_L   = 3'h1;
	localparam logic [2:0] IOD_XREG_PC_DISP = 3'h2;
	localparam logic [2:0] IOD_XREG_PC_IDX  = 3'h3;
	localparam logic [2:0] IOD_XREG_IMM     = 3'h4;

	// ==========================================================
	// Counts and reset values
	// ==========================================================
	localparam logic [2:0] IOD_EXT_NONE = 3'd0;
	localparam logic [2:0] IOD_EXT_ONE  = 3'd1;
	localparam logic [2:0] IOD_EXT_TWO  = 3'd2;
	localparam logic       IOD_VALID_RST = 1'b0;

	typedef enum logic [3:0] {
		IOD_CL_NONE, IOD_CL_SUBR_BRANCH, IOD_CL_QUICK_LOAD, IOD_CL_OR,
		IOD_CL_AND, IOD_CL_XOR, IOD_CL_UDIV, IOD_CL_SDIV, IOD_CL_DEC_SUB,
		IOD_CL_SUB, IOD_CL_ADDR_SUB, IOD_CL_EXT_SUB, IOD_CL_CMP,
		IOD_CL_ADDR_CMP, IOD_CL_MEM_CMP, IOD_CL_UMUL
	} iod_class_t;

	typedef enum logic [1:0] {
		IOD_SZ_BYTE, IOD_SZ_WORD, IOD_SZ_LONG, IOD_SZ_NA
	} iod_size_t;

	typedef struct packed {
		iod_class_t  op_class;
		iod_size_t   size;
		logic        to_ea;
		logic        ccr_only;
		logic        mem_to_mem;
		logic [2:0]  dst_reg;
		logic        dst_is_addr;
		logic [2:0]  src_reg;
		logic        src_is_addr;
		logic        ea_used;
		logic [2:0]  ea_mode;
		logic [2:0]  ea_reg;
		logic [2:0]  ext_words;
		logic [31:0] imm;
		logic        illegal;
		logic        claimed;
	} iod_ctrl_t;

endpackage : iod_pkg

// >>> src/iod_ea_ext.sv
/*
 * Effective-address classifier: extension words and addressing legality.
 * Assumes the caller supplies mode and register fields of one operation word.
 */
module iod_ea_ext
	import iod_pkg::*;
(
	input  wire logic [2:0] mode,
	input  wire logic [2:0] rnum,
	input  wire logic       is_long,
	output logic [2:0]      ext_words,
	output logic            exists,
	output logic            alterable
);

	// ==========================================================
	// Classification
	// ==========================================================
	always_comb begin
		ext_words = IOD_EXT_NONE;
		exists    = 1'b1;
		alterable = 1'b1;
		unique case (mode)
			IOD_MODE_DISP, IOD_MODE_INDEX: ext_words = IOD_EXT_ONE;
			IOD_MODE_EXT: begin
				unique case (rnum)
					IOD_XREG_ABS_W: ext_words = IOD_EXT_ONE;
					IOD_XREG_ABS_L: ext_words = IOD_EXT_TWO;
					IOD_XREG_PC_DISP, IOD_XREG_PC_IDX: begin
						ext_words = IOD_EXT_ONE;
						alterable = 1'b0;
					end
					IOD_XREG_IMM: begin
						// Byte immediates still occupy a whole word
						ext_words = is_long ? IOD_EXT_TWO : IOD_EXT_ONE;
						alterable = 1'b0;
					end
					default: begin
						exists    = 1'b0;
						alterable = 1'b0;
					end
				endcase
			end
			default: ext_words = IOD_EXT_NONE;
		endcase
	end

endmodule : iod_ea_ext

// >>> src/iod_decoder.sv
/*
 * Integer opcode decoder for the branch, quick-load, logical, divide,
 * subtract, compare and multiply group. Decoded controls are registered.
 * Assumes the prefetch unit presents one word per cycle with op_valid and
 * that words outside this group are decoded elsewhere (claimed stays low).
 */
module iod_decoder
	import iod_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        op_valid,
	input  wire logic [15:0] op_word,
	output logic             dec_valid,
	output iod_ctrl_t        dec_ctrl
);

	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic iod_size_t size_of(input logic [1:0] code);
		iod_size_t s;
		s = IOD_SZ_NA;
		unique case (code)
			IOD_SZ_CODE_B: s = IOD_SZ_BYTE;
			IOD_SZ_CODE_W: s = IOD_SZ_WORD;
			IOD_SZ_CODE_L: s = IOD_SZ_LONG;
			default:       s = IOD_SZ_NA;
		endcase
		return s;
	endfunction : size_of

	function automatic logic [31:0] sext8(input logic [7:0] b);
		return {{24{b[7]}}, b};
	endfunction : sext8

	// ==========================================================
	// Field split
	// ==========================================================
	logic [3:0] line;
	logic [2:0] opmode;
	logic [2:0] reg_hi;
	logic [2:0] reg_lo;
	logic [2:0] mode;
	logic [7:0] low_byte;
	logic       pair_form;
	logic       rm_bit;

	assign line      = op_word[15:12];
	assign opmode    = op_word[8:6];
	assign reg_hi    = op_word[11:9];
	assign reg_lo    = op_word[2:0];
	assign mode      = op_word[5:3];
	assign low_byte  = op_word[7:0];
	assign rm_bit    = op_word[3];
	// Register-pair forms hide inside the to-ea opmodes
	assign pair_form = op_word[8] && (op_word[5:4] == IOD_PAIR_FORM);

	// ==========================================================
	// Opcode classification
	// ==========================================================
	iod_ctrl_t base;
	logic      data_src_only;

	always_comb begin
		base               = '0;
		base.op_class      = IOD_CL_NONE;
		base.size          = IOD_SZ_NA;
		base.ea_mode       = mode;
		base.ea_reg        = reg_lo;
		base.dst_reg       = reg_hi;
		base.src_reg       = reg_lo;
		base.ext_words     = IOD_EXT_NONE;
		data_src_only      = 1'b0;
		unique case (line)
			IOD_LINE_BRANCH: begin
				if (op_word[11:8] == IOD_COND_SUBR) begin
					base.claimed  = 1'b1;
					base.op_class = IOD_CL_SUBR_BRANCH;
					if (low_byte == IOD_DISP_WORD) begin
						base.size      = IOD_SZ_WORD;
						base.ext_words = IOD_EXT_ONE;
					end else if (low_byte == IOD_DISP_LONG) begin
						base.size      = IOD_SZ_LONG;
						base.ext_words = IOD_EXT_TWO;
					end else begin
						base.size = IOD_SZ_BYTE;
						base.imm  = sext8(low_byte);
					end
				end
			end
			IOD_LINE_QUICK: begin
				base.claimed  = 1'b1;
				base.op_class = IOD_CL_QUICK_LOAD;
				base.size     = IOD_SZ_LONG;
				base.imm      = sext8(low_byte);
				base.illegal  = op_word[8];
			end
			IOD_LINE_OR: begin
				base.claimed = 1'b1;
				if (opmode == IOD_OPM_WORD_A || opmode == IOD_OPM_LONG_A) begin
					base.op_class = opmode[2] ? IOD_CL_SDIV : IOD_CL_UDIV;
					base.size     = IOD_SZ_WORD;
					base.ea_used  = 1'b1;
					data_src_only = 1'b1;
				end else if (pair_form) begin
					// Only opmode 100 is the decimal form; its neighbours decode elsewhere
					base.claimed     = (opmode == 3'h4);
					base.op_class    = base.claimed ? IOD_CL_DEC_SUB : IOD_CL_NONE;
					base.size        = IOD_SZ_BYTE;
					base.mem_to_mem  = rm_bit;
					base.dst_is_addr = rm_bit;
					base.src_is_addr = rm_bit;
				end else begin
					base.op_class = IOD_CL_OR;
					base.size     = size_of(opmode[1:0]);
					base.to_ea    = opmode[2];
					base.ea_used  = 1'b1;
					data_src_only = 1'b1;
				end
			end
			IOD_LINE_SUB: begin
				base.claimed = 1'b1;
				if (opmode[1:0] == IOD_OPM_ADDR_LOW) begin
					base.op_class    = IOD_CL_ADDR_SUB;
					base.size        = opmode[2] ? IOD_SZ_LONG : IOD_SZ_WORD;
					base.dst_is_addr = 1'b1;
					base.ea_used     = 1'b1;
				end else if (pair_form) begin
					base.op_class    = IOD_CL_EXT_SUB;
					base.size        = size_of(opmode[1:0]);
					base.mem_to_mem  = rm_bit;
					base.dst_is_addr = rm_bit;
					base.src_is_addr = rm_bit;
				end else begin
					base.op_class = IOD_CL_SUB;
					base.size     = size_of(opmode[1:0]);
					base.to_ea    = opmode[2];
					base.ea_used  = 1'b1;
				end
			end
			IOD_LINE_CMP: begin
				base.claimed = 1'b1;
				if (opmode[1:0] == IOD_OPM_ADDR_LOW) begin
					base.op_class    = IOD_CL_ADDR_CMP;
					base.size        = opmode[2] ? IOD_SZ_LONG : IOD_SZ_WORD;
					base.dst_is_addr = 1'b1;
					base.ccr_only    = 1'b1;
					base.ea_used     = 1'b1;
				end else if (op_word[8] && mode == IOD_MODE_AREG) begin
					base.op_class    = IOD_CL_MEM_CMP;
					base.size        = size_of(opmode[1:0]);
					base.mem_to_mem  = 1'b1;
					base.dst_is_addr = 1'b1;
					base.src_is_addr = 1'b1;
					base.ccr_only    = 1'b1;
				end else if (op_word[8]) begin
					base.op_class = IOD_CL_XOR;
					base.size     = size_of(opmode[1:0]);
					base.to_ea    = 1'b1;
					base.ea_used  = 1'b1;
					data_src_only = 1'b1;
				end else begin
					base.op_class = IOD_CL_CMP;
					base.size     = size_of(opmode[1:0]);
					base.ccr_only = 1'b1;
					base.ea_used  = 1'b1;
				end
			end
			IOD_LINE_AND: begin
				// Signed multiply and pair/exchange forms belong to other decoders
				if (opmode == IOD_OPM_WORD_A) begin
					base.claimed  = 1'b1;
					base.op_class = IOD_CL_UMUL;
					base.size     = IOD_SZ_WORD;
					base.ea_used  = 1'b1;
					data_src_only = 1'b1;
				end else if (opmode != IOD_OPM_LONG_A && !pair_form) begin
					base.claimed  = 1'b1;
					base.op_class = IOD_CL_AND;
					base.size     = size_of(opmode[1:0]);
					base.to_ea    = opmode[2];
					base.ea_used  = 1'b1;
					data_src_only = 1'b1;
				end
			end
			default: base.claimed = 1'b0;
		endcase
	end

	// ==========================================================
	// Effective-address checks and extension words
	// ==========================================================
	logic [2:0] ea_ext;
	logic       ea_exists;
	logic       ea_alterable;

	iod_ea_ext u_ea (
		.mode      (mode),
		.rnum      (reg_lo),
		.is_long   (base.size == IOD_SZ_LONG),
		.ext_words (ea_ext),
		.exists    (ea_exists),
		.alterable (ea_alterable)
	);

	iod_ctrl_t next_ctrl;
	logic      bad_ea;

	// Address-register direct cannot feed logic, divide, multiply or byte ops
	always_comb begin
		next_ctrl = base;
		bad_ea    = 1'b0;
		if (base.ea_used) begin
			next_ctrl.ext_words = ea_ext;
			bad_ea = !ea_exists
			      || (base.to_ea && !ea_alterable)
			      || (mode == IOD_MODE_AREG && (data_src_only || base.size == IOD_SZ_BYTE));
		end
		if (base.claimed && (base.size == IOD_SZ_NA || bad_ea)) begin
			next_ctrl.illegal = 1'b1;
		end
		if (base.mem_to_mem) begin
			next_ctrl.ea_mode = IOD_MODE_PREDEC;
		end
	end

	// ==========================================================
	// Output registers
	// ==========================================================
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dec_valid <= IOD_VALID_RST;
		end else if (ce) begin
			dec_valid <= op_valid;
		end
	end

	// Hold last decode while idle so the datapath never sees a glitch
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dec_ctrl <= '0;
		end else if (ce && op_valid) begin
			dec_ctrl <= next_ctrl;
		end
	end

endmodule : iod_decoder

// >>> test/iod_checker.sv
/*
 * Port checker of the opcode decoder.
 * Assumes one clock domain; attached to the decoder by bind.
 */
module iod_checker
	import iod_pkg::*;
(
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        ce,
	input wire logic        op_valid,
	input wire logic [15:0] op_word,
	input wire logic        dec_valid,
	input wire iod_ctrl_t   dec_ctrl
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Helpers
	// ==========================================================
	wire logic       tk = ce && op_valid;
	wire logic [3:0] ln = op_word[15:12];
	wire logic [2:0] om = op_word[8:6];

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// ==========================================================
	// Properties
	// ==========================================================
	take_valid_a: assert property (ce |=> dec_valid == $past(op_valid))
		else $error("dec_valid does not follow a taken word");
	ce_freeze_a: assert property (!ce |=> $stable(dec_ctrl) && $stable(dec_valid))
		else $error("outputs moved while ce low");
	branch_ext_a: assert property (tk && op_word[15:8] == 8'h61 |=> dec_ctrl.op_class == IOD_CL_SUBR_BRANCH
		&& dec_ctrl.ext_words == ($past(op_word[7:0]) == IOD_DISP_WORD ? IOD_EXT_ONE
		: $past(op_word[7:0]) == IOD_DISP_LONG ? IOD_EXT_TWO : IOD_EXT_NONE)) else $error("branch extension wrong");
	quick_imm_a: assert property (tk && ln == IOD_LINE_QUICK && !op_word[8] |=>
		dec_ctrl.imm == {{24{$past(op_word[7])}}, $past(op_word[7:0])} && dec_ctrl.dst_reg == $past(op_word[11:9]))
		else $error("quick load operand wrong");
	div_sel_a: assert property (tk && ln == IOD_LINE_OR && om[1:0] == IOD_OPM_ADDR_LOW |=>
		dec_ctrl.op_class == ($past(op_word[8]) ? IOD_CL_SDIV : IOD_CL_UDIV)) else $error("divide kind wrong");
	cmp_flags_a: assert property (tk && ln == IOD_LINE_CMP && !op_word[8] |=>
		dec_ctrl.ccr_only && !dec_ctrl.to_ea) else $error("compare writes a result");
	dir_size_a: assert property (tk && (ln == IOD_LINE_OR || ln == IOD_LINE_SUB || ln == IOD_LINE_AND)
		&& om[1:0] != IOD_OPM_ADDR_LOW && op_word[5:4] != 2'h0 |=> dec_ctrl.to_ea == $past(op_word[8])
		&& dec_ctrl.size == iod_size_t'($past(op_word[7:6]))) else $error("direction or size wrong");
	pair_mode_a: assert property (tk && op_word[8] && op_word[5:4] == 2'h0 && (ln == IOD_LINE_SUB
		&& om[1:0] != 2'h3 || ln == IOD_LINE_OR && om == 3'h4) |=> dec_ctrl.mem_to_mem == $past(op_word[3]))
		else $error("pair form mode wrong");
	mem_cmp_a: assert property (tk && ln == IOD_LINE_CMP && op_word[8] && om[1:0] != 2'h3
		&& op_word[5:3] == IOD_MODE_AREG |=> dec_ctrl.op_class == IOD_CL_MEM_CMP
		&& dec_ctrl.size == iod_size_t'($past(op_word[7:6]))) else $error("memory compare wrong");

	cover property (tk && op_word[15:8] == 8'h61);
	cover property (!ce && op_valid);
	cover property (dec_valid && dec_ctrl.illegal);
endmodule : iod_checker

bind iod_decoder iod_checker i_chk (.mclk(mclk), .nrst(nrst), .ce(ce), .op_valid(op_valid),
	.op_word(op_word), .dec_valid(dec_valid), .dec_ctrl(dec_ctrl));

// >>> test/iod_prefetch.sv
/*
 * Prefetch model: hands one operation word per cycle to the decoder.
 * Assumes the bench calls send and idle from a single process.
 */
module iod_prefetch
	import iod_pkg::*;
(
	input  wire logic   mclk,
	output logic        op_valid,
	output logic [15:0] op_word
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		op_valid = 1'b0;
		op_word  = 16'h0000;
	end

	task automatic send(input logic [15:0] w);
		@(negedge mclk);
		op_valid <= 1'b1;
		op_word  <= w;
	endtask : send

	// Stale word toggles, so it never passes for data
	task automatic idle();
		@(negedge mclk);
		op_valid <= 1'b0;
		op_word  <= ~op_word;
	endtask : idle
endmodule : iod_prefetch

// >>> test/tb_integer_opcode_decoder.sv
/*
 * Self-checking bench of the opcode decoder: notes in a queue, a monitor compares.
 * Assumes the package constants and the bound checker.
 */
module tb_integer_opcode_decoder
	import iod_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		iod_ctrl_t e;
		iod_ctrl_t m;
	} iod_note_t;

	logic        mclk;
	logic        nrst;
	logic        ce;
	logic        op_valid;
	logic [15:0] op_word;
	logic        dec_valid;
	iod_ctrl_t   dec_ctrl;
	iod_note_t   notes[$];
	iod_note_t   n;
	iod_ctrl_t   e, m0, mc, mx;
	iod_class_t  c;
	logic [2:0]  o;
	logic [31:0] r;
	int          fails, compares, seed, cyc, k, i;
	logic [3:0]  lt[4] = '{4'h8, 4'h9, 4'hb, 4'hc};

	iod_decoder i_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .op_valid(op_valid), .op_word(op_word),
		.dec_valid(dec_valid), .dec_ctrl(dec_ctrl));
	iod_prefetch pf (.mclk(mclk), .op_valid(op_valid), .op_word(op_word));

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict

	function automatic iod_ctrl_t mk(iod_class_t cl, iod_size_t s, logic [2:0] f, logic [2:0] d, logic [2:0] x,
		logic [31:0] imm);
		mk = '0;
		mk.op_class = cl;
		mk.size = s;
		{mk.to_ea, mk.ccr_only, mk.mem_to_mem} = f;
		mk.dst_reg = d;
		mk.ext_words = x;
		mk.imm = imm;
		mk.claimed = 1'b1;
	endfunction : mk

	// Register-pair forms: rm picks address registers, mm memory with predecrement
	function automatic iod_ctrl_t pk(iod_class_t cl, iod_size_t s, logic rm, logic mm);
		pk = mk(cl, s, {1'b0, cl == IOD_CL_MEM_CMP, mm}, 3'h3, 3'h0, 32'h0);
		{pk.dst_is_addr, pk.src_is_addr} = {2{rm}};
		pk.ea_mode = mm ? IOD_MODE_PREDEC : IOD_MODE_DREG;
	endfunction : pk

	task automatic put(input logic [15:0] w, input iod_ctrl_t ex, input iod_ctrl_t mm);
		notes.push_back('{iod_ctrl_t'(ex & mm), mm});
		pf.send(w);
	endtask : put

	// ==========================================================
	// Clock, monitor, timeout
	// ==========================================================
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	always @(negedge mclk) begin
		// Frozen dec_valid under low ce is no new result; ce moves by NBA here
		if (dec_valid === 1'b1 && ce === 1'b1) begin
			if (notes.size() == 0) check("extra result", 64'h1, 64'h0);
			else begin
				n = notes.pop_front();
				check("decode", 64'(dec_ctrl & n.m), 64'(n.e));
			end
		end
	end

	// Run needs under 200 cycles; ceiling is ten times that
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			print_verdict();
		end
	end

	// ==========================================================
	// Stimulus
	// ==========================================================
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		seed = 30438;
		m0 = '1;
		{m0.dst_is_addr, m0.src_reg, m0.src_is_addr, m0.ea_used, m0.ea_mode, m0.ea_reg} = '0;
		mc = m0;
		// Pair forms also check register kinds and the forced addressing mode
		{mc.dst_is_addr, mc.src_is_addr, mc.ea_mode} = '1;
		mx = '0;
		{mx.illegal, mx.claimed} = 2'h3;
		repeat (3) @(posedge mclk);
		@(negedge mclk) nrst = 1'b1;
		put(16'h6100, mk(IOD_CL_SUBR_BRANCH, IOD_SZ_WORD, 3'h0, 3'h0, IOD_EXT_ONE, 32'h0), m0);
		put(16'h61ff, mk(IOD_CL_SUBR_BRANCH, IOD_SZ_LONG, 3'h0, 3'h0, IOD_EXT_TWO, 32'h0), m0);
		put(16'h6180, mk(IOD_CL_SUBR_BRANCH, IOD_SZ_BYTE, 3'h0, 3'h0, IOD_EXT_NONE, 32'hffffff80), m0);
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			put({4'h7, r[2:0], 1'b0, r[7:0]}, mk(IOD_CL_QUICK_LOAD, IOD_SZ_LONG, 3'h0, r[2:0], 3'h0,
				{{24{r[7]}}, r[7:0]}), m0);
		end
		for (k = 0; k < 4; k++) for (i = 0; i < 8; i++) begin
			o = i[2:0];
			case (k)
				0: c = o == 3'h3 ? IOD_CL_UDIV : o == 3'h7 ? IOD_CL_SDIV : IOD_CL_OR;
				1: c = o[1:0] == 2'h3 ? IOD_CL_ADDR_SUB : IOD_CL_SUB;
				2: c = o[1:0] == 2'h3 ? IOD_CL_ADDR_CMP : o[2] ? IOD_CL_XOR : IOD_CL_CMP;
				default: c = o == 3'h3 ? IOD_CL_UMUL : IOD_CL_AND;
			endcase
			if (k == 3 && o == 3'h7) continue;
			// Divide takes a word source in both opmodes, multiply in opmode 3
			e = mk(c, o[1:0] == 2'h3 ? (o[2] && (k == 1 || k == 2) ? IOD_SZ_LONG : IOD_SZ_WORD) : iod_size_t'(o[1:0]),
				{o[2] && o[1:0] != 2'h3, k == 2 && (!o[2] || o == 3'h7), 1'b0}, 3'h3, 3'h0, 32'h0);
			put({lt[k], 3'h3, o, 6'h11}, e, m0);
		end
		for (i = 0; i < 6; i++) begin
			o = i[2:0] >> 1;
			if (i < 2) put({8'h87, 4'h0, i[0], 3'h1}, pk(IOD_CL_DEC_SUB, IOD_SZ_BYTE, i[0], i[0]), mc);
			put({8'h97, o[1:0], 2'h0, i[0], 3'h1}, pk(IOD_CL_EXT_SUB, iod_size_t'(o[1:0]), i[0], i[0]), mc);
			put({8'hb7, o[1:0], 6'h09}, pk(IOD_CL_MEM_CMP, iod_size_t'(o[1:0]), 1'b1, 1'b1), mc);
		end
		put(16'h8639, mk(IOD_CL_OR, IOD_SZ_BYTE, 3'h0, 3'h3, IOD_EXT_TWO, 32'h0), m0);
		put(16'h8629, mk(IOD_CL_OR, IOD_SZ_BYTE, 3'h0, 3'h3, IOD_EXT_ONE, 32'h0), m0);
		put(16'h86bc, mk(IOD_CL_OR, IOD_SZ_LONG, 3'h0, 3'h3, IOD_EXT_TWO, 32'h0), m0);
		e = mx;
		put(16'h7780, e, mx);
		put(16'h8609, e, mx);
		put(16'h4e71, '0, mx);
		pf.idle();
		ce <= 1'b0;
		pf.send(16'h6100);
		pf.idle();
		check("frozen ctrl", 64'(dec_ctrl.claimed), 64'h0);
		ce <= 1'b1;
		repeat (3) pf.idle();
		nrst = 1'b0;
		#1;
		check("reset valid", 64'(dec_valid), 64'h0);
		check("reset ctrl", 64'(dec_ctrl), 64'h0);
		@(negedge mclk) nrst = 1'b1;
		put(16'h61ff, mk(IOD_CL_SUBR_BRANCH, IOD_SZ_LONG, 3'h0, 3'h0, IOD_EXT_TWO, 32'h0), m0);
		repeat (3) pf.idle();
		check("pending notes", 64'(notes.size()), 64'h0);
		print_verdict();
	end
endmodule : tb_integer_opcode_decoder
